// *** shared/dcdc_pkg.sv ***
// Purpose: Shared constants and types for the dc-dc converter configuration and mode registers.
// Assumes: 8-bit special-function-register space selected by page and address.
// Notes: Field layouts of both registers are packed structs in bit order.
package dcdc_pkg;

  // Register placement in the special-function-register space
  localparam logic [7:0] CONV_CFG_ADDR = 8'h96;
  localparam logic [7:0] CONV_CFG_PAGE = 8'h00;
  localparam logic [7:0] CONV_MODE_ADDR = 8'h94;
  localparam logic [7:0] CONV_MODE_PAGE = 8'h0f;

  // Reset values
  localparam logic [7:0] CONV_CFG_RESET = 8'h00;
  localparam logic [2:0] CONV_MODE_RESET = 3'h0;

  // Value returned for an unmapped read
  localparam logic [7:0] SFR_UNMAPPED = 8'h00;

  // Upper nibble of the mode register
  localparam logic [3:0] MODE_UNUSED_VAL = 4'h0;

  // Bypass select codes
  typedef enum logic [1:0] {
    BYP_DISABLED = 2'h0,
    BYP_AUTO_OSC = 2'h1,
    BYP_AUTO_LOW = 2'h2,
    BYP_FORCED = 2'h3
  } bypass_sel_t;

  // Bypass state, one-hot
  typedef enum logic [1:0] {
    BYP_IDLE = 2'b01,
    BYP_ACTIVE = 2'b10
  } byp_state_t;

  // Configuration register layout, bit 7 down to bit 0
  typedef struct packed {
    logic low_power_enable;
    logic [1:0] conv_clock_divider;
    logic sar_clock_phase_select;
    logic conv_clock_invert;
    logic peak_current_threshold;
    logic sleep_output_connection;
    logic conv_clock_source;
  } conv_cfg_t;

  // Mode register layout, bit 7 down to bit 0
  typedef struct packed {
    logic [3:0] unused;
    logic bypass_active_flag;
    bypass_sel_t bypass_select;
    logic passive_diode_enable;
  } conv_mode_t;

  // Settings that steer the converter clock path
  typedef struct packed {
    logic source;
    logic invert;
    logic [1:0] divider;
  } clk_set_t;

  // Clock source codes
  localparam logic SRC_LOCAL = 1'b0;
  localparam logic SRC_SYSTEM = 1'b1;

endpackage

// *** verilog/conv_clock_gen.sv ***
// Purpose: Converter clock derivation from local oscillator or divided system clock.
// Assumes: lo_osc_level is synchronous to clk; edges of the converter clock are reported as ticks.
// Notes: New settings are only adopted at a safe point, so no period is cut short.
`timescale 1ns/1ps
module conv_clock_gen #(
  parameter int CNT_W = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Requested settings
  input dcdc_pkg::clk_set_t settings,
  input wire logic lo_osc_level,
  // Converter clock
  output logic conv_clk_tick,
  output logic conv_clk_on_fall
);
  import dcdc_pkg::*;

  // Divide by 8 needs a three-bit count
  if (CNT_W < 3) begin : g_bad_width
    $error("conv_clock_gen: CNT_W must be at least 3");
  end

  clk_set_t active_r, active_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic lo_prev_r, lo_prev_nxt;
  logic tick_r, tick_nxt;
  logic fall_r, fall_nxt;
  logic [CNT_W-1:0] last;
  logic period_end;
  logic safe;

  // Last count of a divided period
  always_comb begin
    unique case (active_r.divider)
      2'h0: last = CNT_W'(0);
      2'h1: last = CNT_W'(1);
      2'h2: last = CNT_W'(3);
      2'h3: last = CNT_W'(7);
    endcase
  end

  // Period end and the point where settings may change
  always_comb begin
    lo_prev_nxt = lo_osc_level;
    if (active_r.source == SRC_SYSTEM) begin
      period_end = (cnt_r == last);
      safe = period_end;
    end else begin
      period_end = lo_osc_level & ~lo_prev_r;
      // Low phase of the oscillator is a runt-free switch point
      safe = ~lo_osc_level;
    end
    tick_nxt = period_end;
    active_nxt = safe ? settings : active_r;
    if (safe || active_r.source == SRC_LOCAL) begin
      cnt_nxt = '0;
    end else begin
      cnt_nxt = cnt_r + CNT_W'(1);
    end
    // Inverted system clock puts edges on the falling edge of clk
    fall_nxt = (active_nxt.source == SRC_SYSTEM) & active_nxt.invert;
  end

  // State registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      active_r <= '0;
      cnt_r <= '0;
      lo_prev_r <= 1'b0;
      tick_r <= 1'b0;
      fall_r <= 1'b0;
    end else begin
      active_r <= active_nxt;
      cnt_r <= cnt_nxt;
      lo_prev_r <= lo_prev_nxt;
      tick_r <= tick_nxt;
      fall_r <= fall_nxt;
    end
  end

  assign conv_clk_tick = tick_r;
  assign conv_clk_on_fall = fall_r;

endmodule // conv_clock_gen

// *** verilog/bypass_ctrl.sv ***
// Purpose: Bypass switch control from the bypass select code.
// Assumes: vin_above_vout comes from the analog comparator, synchronous to clk.
// Notes: Passive diode mode withdraws drive from the bypass switch.
`timescale 1ns/1ps
module bypass_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Settings and conditions
  input dcdc_pkg::bypass_sel_t bypass_select,
  input wire logic passive_diode,
  input wire logic vin_above_vout,
  // Controls and status
  output logic bypass_switch_on,
  output logic bypass_drive_en,
  output logic conv_osc_run,
  output logic bypass_active
);
  import dcdc_pkg::*;

  byp_state_t state_r, state_nxt;
  logic sw_r, sw_nxt;
  logic drv_r, drv_nxt;
  logic osc_r, osc_nxt;

  // Next bypass state and controls
  always_comb begin
    unique case (bypass_select)
      BYP_DISABLED: state_nxt = BYP_IDLE;
      BYP_AUTO_OSC: state_nxt = vin_above_vout ? BYP_ACTIVE : BYP_IDLE;
      BYP_AUTO_LOW: state_nxt = vin_above_vout ? BYP_ACTIVE : BYP_IDLE;
      BYP_FORCED: state_nxt = BYP_ACTIVE;
    endcase
    // While bypassed, the oscillator is kept for fast response only in the first auto mode
    osc_nxt = !(state_nxt == BYP_ACTIVE && bypass_select != BYP_AUTO_OSC);
    drv_nxt = ~passive_diode;
    sw_nxt = (state_nxt == BYP_ACTIVE) & ~passive_diode;
  end

  // State registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= BYP_IDLE;
      sw_r <= 1'b0;
      drv_r <= 1'b1;
      osc_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      sw_r <= sw_nxt;
      drv_r <= drv_nxt;
      osc_r <= osc_nxt;
    end
  end

  assign bypass_switch_on = sw_r;
  assign bypass_drive_en = drv_r;
  assign conv_osc_run = osc_r;
  assign bypass_active = (state_r == BYP_ACTIVE);

endmodule // bypass_ctrl

// *** verilog/dcdc_config_mode_regs.sv ***
// Purpose: Configuration and mode registers of the step-up dc-dc converter.
// Assumes: Register access over the special-function-register strobes; sync enable comes from the control register.
// Notes: Read data is registered and valid one cycle after the read strobe.
`timescale 1ns/1ps
module dcdc_config_mode_regs #(
  parameter int DIV_CNT_W = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Special-function-register access
  input wire logic [7:0] sfr_page,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_rdata_valid,
  // Neighbouring control and power state
  input wire logic sync_enable,
  input wire logic sleep_mode,
  input wire logic converter_enable,
  // Analog side inputs
  input wire logic lo_osc_level,
  input wire logic vin_above_vout,
  // Converter regime controls
  output logic low_power_mode,
  output logic peak_current_threshold,
  output logic vdd_to_battery,
  output logic vdd_floating,
  // Converter and sampler clocks
  output logic conv_clk_tick,
  output logic conv_clk_on_fall,
  output logic sar_clk_tick,
  output logic sar_clk_inverted,
  output logic sampler_track_strobe,
  // Bypass controls
  output logic bypass_switch_on,
  output logic bypass_drive_en,
  output logic conv_osc_run,
  output logic passive_diode_mode
);
  import dcdc_pkg::*;

  // Width check for the divider counter
  if (DIV_CNT_W < 3) begin : g_bad_width
    $error("dcdc_config_mode_regs: DIV_CNT_W must be at least 3");
  end

  // Register state
  conv_cfg_t cfg_r, cfg_nxt;
  logic passive_r, passive_nxt;
  bypass_sel_t bsel_r, bsel_nxt;

  // Read port state
  logic [7:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;

  // Derived output state
  logic lp_r, lp_nxt;
  logic ilim_r, ilim_nxt;
  logic vbat_r, vbat_nxt;
  logic vfloat_r, vfloat_nxt;
  logic sar_tick_r, sar_tick_nxt;
  logic sar_inv_r, sar_inv_nxt;
  logic track_r, track_nxt;

  // Decode and helper nets
  logic hit_cfg;
  logic hit_mode;
  logic bypass_active;
  logic conv_tick;
  conv_mode_t mode_view;
  conv_cfg_t wr_cfg;
  conv_mode_t wr_mode;
  clk_set_t clk_set;

  // Register select needs both page and address to match
  assign hit_cfg = (sfr_page == CONV_CFG_PAGE) && (sfr_addr == CONV_CFG_ADDR);
  assign hit_mode = (sfr_page == CONV_MODE_PAGE) && (sfr_addr == CONV_MODE_ADDR);
  assign wr_cfg = conv_cfg_t'(sfr_wdata);
  assign wr_mode = conv_mode_t'(sfr_wdata);

  // Mode register as seen by software
  always_comb begin
    mode_view.unused = MODE_UNUSED_VAL;
    mode_view.bypass_active_flag = bypass_active;
    mode_view.bypass_select = bsel_r;
    mode_view.passive_diode_enable = passive_r;
  end

  // Register writes
  always_comb begin
    cfg_nxt = cfg_r;
    bsel_nxt = bsel_r;
    passive_nxt = passive_r;
    if (sfr_wr && hit_cfg) begin
      cfg_nxt = wr_cfg;
    end
    if (sfr_wr && hit_mode) begin
      // Flag and upper nibble are not writable
      bsel_nxt = wr_mode.bypass_select;
      passive_nxt = wr_mode.passive_diode_enable;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg_r <= conv_cfg_t'(CONV_CFG_RESET);
      bsel_r <= bypass_sel_t'(CONV_MODE_RESET[2:1]);
      passive_r <= CONV_MODE_RESET[0];
    end else begin
      cfg_r <= cfg_nxt;
      bsel_r <= bsel_nxt;
      passive_r <= passive_nxt;
    end
  end

  // Register reads; unmapped addresses return a fixed value
  always_comb begin
    rdata_nxt = rdata_r;
    rvalid_nxt = sfr_rd;
    if (sfr_rd) begin
      if (hit_cfg) begin
        rdata_nxt = cfg_r;
      end else if (hit_mode) begin
        rdata_nxt = mode_view;
      end else begin
        rdata_nxt = SFR_UNMAPPED;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // Converter clock path settings
  always_comb begin
    clk_set.source = cfg_r.conv_clock_source;
    clk_set.invert = cfg_r.conv_clock_invert;
    clk_set.divider = cfg_r.conv_clock_divider;
  end

  // Clock derivation; settings change only at safe points
  conv_clock_gen #(
    .CNT_W(DIV_CNT_W)
  ) u_clock_gen (
    .clk(clk),
    .rstn(rstn),
    .settings(clk_set),
    .lo_osc_level(lo_osc_level),
    .conv_clk_tick(conv_tick),
    .conv_clk_on_fall(conv_clk_on_fall)
  );

  // Bypass control from the mode register
  bypass_ctrl u_bypass (
    .clk(clk),
    .rstn(rstn),
    .bypass_select(bsel_r),
    .passive_diode(passive_r),
    .vin_above_vout(vin_above_vout),
    .bypass_switch_on(bypass_switch_on),
    .bypass_drive_en(bypass_drive_en),
    .conv_osc_run(conv_osc_run),
    .bypass_active(bypass_active)
  );

  // Regime, limit and sleep connection controls
  always_comb begin
    lp_nxt = cfg_r.low_power_enable;
    ilim_nxt = cfg_r.peak_current_threshold;
    // Connection only matters in sleep with the converter on
    vbat_nxt = sleep_mode & converter_enable & ~cfg_r.sleep_output_connection;
    vfloat_nxt = sleep_mode & converter_enable & cfg_r.sleep_output_connection;
  end

  // Sampler clocking follows the converter only while synced
  always_comb begin
    sar_tick_nxt = sync_enable & conv_tick;
    track_nxt = sync_enable & conv_tick;
    // Phase bit low means inverted; without sync it has no effect
    sar_inv_nxt = sync_enable & ~cfg_r.sar_clock_phase_select;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      lp_r <= 1'b0;
      ilim_r <= 1'b0;
      vbat_r <= 1'b0;
      vfloat_r <= 1'b0;
      sar_tick_r <= 1'b0;
      sar_inv_r <= 1'b0;
      track_r <= 1'b0;
    end else begin
      lp_r <= lp_nxt;
      ilim_r <= ilim_nxt;
      vbat_r <= vbat_nxt;
      vfloat_r <= vfloat_nxt;
      sar_tick_r <= sar_tick_nxt;
      sar_inv_r <= sar_inv_nxt;
      track_r <= track_nxt;
    end
  end

  // Output assignments
  assign sfr_rdata = rdata_r;
  assign sfr_rdata_valid = rvalid_r;
  assign low_power_mode = lp_r;
  assign peak_current_threshold = ilim_r;
  assign vdd_to_battery = vbat_r;
  assign vdd_floating = vfloat_r;
  assign conv_clk_tick = conv_tick;
  assign sar_clk_tick = sar_tick_r;
  assign sar_clk_inverted = sar_inv_r;
  assign sampler_track_strobe = track_r;
  assign passive_diode_mode = passive_r;

endmodule // dcdc_config_mode_regs

// *** verification/dcdc_config_mode_regs_props.sv ***
// Purpose: Port-level assertions for the converter register block.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Sees only the top module's ports.
`timescale 1ns/1ps
module dcdc_config_mode_regs_props
  import dcdc_pkg::*;
#(
  parameter int DIV_CNT_W = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register access
  input wire logic [7:0] sfr_page,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_rdata_valid,
  // Conditions
  input wire logic sync_enable,
  input wire logic sleep_mode,
  input wire logic converter_enable,
  input wire logic lo_osc_level,
  input wire logic vin_above_vout,
  // Outputs watched
  input wire logic low_power_mode,
  input wire logic peak_current_threshold,
  input wire logic vdd_to_battery,
  input wire logic vdd_floating,
  input wire logic conv_clk_tick,
  input wire logic conv_clk_on_fall,
  input wire logic sar_clk_tick,
  input wire logic sar_clk_inverted,
  input wire logic sampler_track_strobe,
  input wire logic bypass_switch_on,
  input wire logic bypass_drive_en,
  input wire logic conv_osc_run,
  input wire logic passive_diode_mode
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // Config writes reach the regime outputs two edges later
  AST_LOW_POWER: assert property ((sfr_wr && sfr_page == CONV_CFG_PAGE && sfr_addr == CONV_CFG_ADDR)
    |-> ##2 low_power_mode == $past(sfr_wdata[7], 2)) else $error("low power output wrong");
  AST_THRESHOLD: assert property ((sfr_wr && sfr_page == CONV_CFG_PAGE && sfr_addr == CONV_CFG_ADDR)
    |-> ##2 peak_current_threshold == $past(sfr_wdata[2], 2)) else $error("threshold output wrong");
  // Mode reads never show the unused nibble
  AST_MODE_NIBBLE: assert property ((sfr_rd && sfr_page == CONV_MODE_PAGE && sfr_addr == CONV_MODE_ADDR)
    |=> sfr_rdata_valid && sfr_rdata[7:4] == MODE_UNUSED_VAL) else $error("mode upper nibble not zero");
  // Sampler clock only follows while synchronised
  AST_SAR_GATED: assert property (!sync_enable |=> !sar_clk_inverted && !sar_clk_tick)
    else $error("sampler clock active without sync");
  AST_SAR_TICK: assert property (sar_clk_tick |-> $past(conv_clk_tick) && $past(sync_enable))
    else $error("sampler tick without converter tick");
  AST_TRACK: assert property (sampler_track_strobe == sar_clk_tick)
    else $error("track strobe misaligned");
  // Sleep connection: exactly one of the two while asleep and enabled
  AST_VDD_ON: assert property ((sleep_mode && converter_enable) |=> vdd_to_battery != vdd_floating)
    else $error("sleep connection ambiguous");
  AST_VDD_OFF: assert property (!(sleep_mode && converter_enable) |=> !vdd_to_battery && !vdd_floating)
    else $error("sleep connection outside sleep");
  AST_PASSIVE: assert property (passive_diode_mode |=> !bypass_switch_on && !bypass_drive_en)
    else $error("bypass switch driven in passive mode");

  // Main scenarios reached
  cover property (sar_clk_tick);
  cover property (bypass_switch_on && !conv_osc_run);
  cover property (vdd_floating);
  cover property (conv_clk_on_fall);
endmodule // dcdc_config_mode_regs_props

bind dcdc_config_mode_regs dcdc_config_mode_regs_props #(.DIV_CNT_W(DIV_CNT_W)) u_dcdc_config_mode_regs_props (
  .clk(clk), .rstn(rstn), .sfr_page(sfr_page), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_rdata_valid(sfr_rdata_valid), .sync_enable(sync_enable),
  .sleep_mode(sleep_mode), .converter_enable(converter_enable), .lo_osc_level(lo_osc_level),
  .vin_above_vout(vin_above_vout), .low_power_mode(low_power_mode), .peak_current_threshold(peak_current_threshold),
  .vdd_to_battery(vdd_to_battery), .vdd_floating(vdd_floating), .conv_clk_tick(conv_clk_tick),
  .conv_clk_on_fall(conv_clk_on_fall), .sar_clk_tick(sar_clk_tick), .sar_clk_inverted(sar_clk_inverted),
  .sampler_track_strobe(sampler_track_strobe), .bypass_switch_on(bypass_switch_on),
  .bypass_drive_en(bypass_drive_en), .conv_osc_run(conv_osc_run), .passive_diode_mode(passive_diode_mode));

// *** verification/tb_dcdc_config_mode_regs.sv ***
// Purpose: Self-checking bench for the converter register block.
// Assumes: One-cycle register strobes; read data one cycle later.
// Notes: Inputs change on the rising edge; outputs sampled on the falling edge.
`timescale 1ns/1ps
module tb_dcdc_config_mode_regs;
  import dcdc_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] sfr_page = 8'h00;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic sync_enable = 1'b0;
  logic sleep_mode = 1'b0;
  logic converter_enable = 1'b0;
  logic lo_osc_level = 1'b0;
  logic vin_above_vout = 1'b0;
  logic lo_run = 1'b0;
  logic [7:0] sfr_rdata;
  logic sfr_rdata_valid, low_power_mode, peak_current_threshold, vdd_to_battery, vdd_floating;
  logic conv_clk_tick, conv_clk_on_fall, sar_clk_tick, sar_clk_inverted, sampler_track_strobe;
  logic bypass_switch_on, bypass_drive_en, conv_osc_run, passive_diode_mode;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;

  dcdc_config_mode_regs #(.DIV_CNT_W(3)) u_dcdc_config_mode_regs (
    .clk(clk), .rstn(rstn), .sfr_page(sfr_page), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_rdata_valid(sfr_rdata_valid), .sync_enable(sync_enable),
    .sleep_mode(sleep_mode), .converter_enable(converter_enable), .lo_osc_level(lo_osc_level),
    .vin_above_vout(vin_above_vout), .low_power_mode(low_power_mode),
    .peak_current_threshold(peak_current_threshold), .vdd_to_battery(vdd_to_battery),
    .vdd_floating(vdd_floating), .conv_clk_tick(conv_clk_tick), .conv_clk_on_fall(conv_clk_on_fall),
    .sar_clk_tick(sar_clk_tick), .sar_clk_inverted(sar_clk_inverted),
    .sampler_track_strobe(sampler_track_strobe), .bypass_switch_on(bypass_switch_on),
    .bypass_drive_en(bypass_drive_en), .conv_osc_run(conv_osc_run), .passive_diode_mode(passive_diode_mode));

  // 10 MHz clock
  always #50 clk = ~clk;
  // Local oscillator at half the clock rate, parked low otherwise
  always @(posedge clk) lo_osc_level <= lo_run ? ~lo_osc_level : 1'b0;
  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("Checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    sfr_page <= pg;
    sfr_addr <= ad;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
    gap(3);
  endtask

  // Read strobe, then data and valid judged one cycle on
  task automatic rd(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] exp);
    @(posedge clk);
    sfr_page <= pg;
    sfr_addr <= ad;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    @(negedge clk);
    chk("valid", 8'h01, {7'h0, sfr_rdata_valid});
    chk("rdata", exp, sfr_rdata);
  endtask

  // Cycles between two converter ticks after settling
  task automatic per(input logic [7:0] exp);
    int n;
    gap(20);
    n = 0;
    while (conv_clk_tick !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    n = 1;
    while (conv_clk_tick !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk("period", exp, n[7:0]);
  endtask

  task automatic t_reset();
    rd(CONV_CFG_PAGE, CONV_CFG_ADDR, CONV_CFG_RESET);
    rd(CONV_MODE_PAGE, CONV_MODE_ADDR, 8'h00);
    chk("drive_en", 8'h01, {7'h0, bypass_drive_en});
  endtask

  // Level inputs change on a rising edge, like the strobes
  task automatic t_regs();
    wr(CONV_CFG_PAGE, CONV_CFG_ADDR, 8'h84);
    chk("low_power", 8'h01, {7'h0, low_power_mode});
    chk("threshold", 8'h01, {7'h0, peak_current_threshold});
    rd(CONV_CFG_PAGE, CONV_CFG_ADDR, 8'h84);
    @(posedge clk);
    sync_enable <= 1'b1;
    wr(CONV_CFG_PAGE, CONV_CFG_ADDR, 8'h00);
    chk("low_power", 8'h00, {7'h0, low_power_mode});
    chk("sar_inv", 8'h01, {7'h0, sar_clk_inverted});
    wr(CONV_CFG_PAGE, CONV_CFG_ADDR, 8'h10);
    chk("sar_inv", 8'h00, {7'h0, sar_clk_inverted});
    @(posedge clk);
    sync_enable <= 1'b0;
    wr(CONV_CFG_PAGE, CONV_CFG_ADDR, 8'h00);
    chk("sar_inv", 8'h00, {7'h0, sar_clk_inverted});
  endtask

  task automatic t_sleep();
    @(posedge clk);
    sleep_mode <= 1'b1;
    converter_enable <= 1'b1;
    wr(CONV_CFG_PAGE, CONV_CFG_ADDR, 8'h00);
    chk("to_battery", 8'h01, {7'h0, vdd_to_battery});
    wr(CONV_CFG_PAGE, CONV_CFG_ADDR, 8'h02);
    chk("floating", 8'h01, {7'h0, vdd_floating});
    @(posedge clk);
    sleep_mode <= 1'b0;
  endtask

  // Every bypass code with the comparator low and high; bits 7:3 written as ones
  task automatic t_bypass();
    logic on;
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      vin_above_vout <= k[0];
      wr(CONV_MODE_PAGE, CONV_MODE_ADDR, {5'h1f, k[2:1], 1'b0});
      on = (k[2:1] == 2'h3) || (k[2:1] != 2'h0 && k[0]);
      chk("switch", {7'h0, on}, {7'h0, bypass_switch_on});
      chk("osc_run", {7'h0, !(on && k[2])}, {7'h0, conv_osc_run});
      rd(CONV_MODE_PAGE, CONV_MODE_ADDR, {4'h0, on, k[2:1], 1'b0});
    end
    wr(CONV_MODE_PAGE, CONV_MODE_ADDR, 8'h07);
    chk("passive", 8'h01, {7'h0, passive_diode_mode});
    chk("switch", 8'h00, {7'h0, bypass_switch_on});
    chk("drive_en", 8'h00, {7'h0, bypass_drive_en});
    rd(CONV_MODE_PAGE, CONV_MODE_ADDR, 8'h0f);
    wr(CONV_MODE_PAGE, CONV_MODE_ADDR, 8'h00);
  endtask

  // A new setting waits for the end of the running divide-by-8 period
  task automatic t_clock();
    @(posedge clk);
    sync_enable <= 1'b1;
    for (int d = 0; d < 4; d++) begin
      wr(CONV_CFG_PAGE, CONV_CFG_ADDR, {1'b0, d[1:0], 5'h01});
      per(8'h01 << d);
    end
    wr(CONV_CFG_PAGE, CONV_CFG_ADDR, 8'h09);
    chk("on_fall", 8'h00, {7'h0, conv_clk_on_fall});
    gap(8);
    chk("on_fall", 8'h01, {7'h0, conv_clk_on_fall});
    per(8'h01);
    chk("sar_tick", 8'h01, {7'h0, sar_clk_tick});
    lo_run <= 1'b1;
    wr(CONV_CFG_PAGE, CONV_CFG_ADDR, 8'h60);
    per(8'h02);
    chk("on_fall", 8'h00, {7'h0, conv_clk_on_fall});
    lo_run <= 1'b0;
    @(posedge clk);
    sync_enable <= 1'b0;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_regs();
    t_sleep();
    t_bypass();
    t_clock();
    summarize();
  end
endmodule // tb_dcdc_config_mode_regs
